// ==== include/insn_timing_defines.svh ====
// Constants for the instruction length and timing decoder
// Assumes the classic 8-bit core opcode map and a single system clock
`ifndef INSN_TIMING_DEFINES_SVH
`define INSN_TIMING_DEFINES_SVH
`define OP_NOP        8'h00
`define OP_UNUSED     8'ha5
`define OP_MOVC_DP    8'h93
`define OP_MOVC_PC    8'h83
`define OP_MOVX_RD_R  8'he2
`define OP_MOVX_WR_R  8'hf2
`define OP_MOVX_RD_D  8'he0
`define OP_MOVX_WR_D  8'hf0
`define OP_MOV_DP     8'h90
`define OP_CLR_A      8'he4
`define OP_CPL_A      8'hf4
`define OP_RL_A       8'h23
`define OP_RLC_A      8'h33
`define OP_RR_A       8'h03
`define OP_RRC_A      8'h13
`define OP_SWAP_A     8'hc4
`define OP_XCHD_0     8'hd6
`define OP_XCHD_1     8'hd7
`define OP_PUSH       8'hc0
`define OP_POP        8'hd0
`define OP_JC         8'h40
`define OP_JNC        8'h50
`define OP_JB         8'h20
`define OP_JNB        8'h30
`define OP_JBC        8'h10
`define OP_JMP_IND    8'h73
`define OP_CJNE_DIR   8'hb5
`define OP_JZ         8'h60
`define OP_JNZ        8'h70
`define OP_DJNZ_DIR   8'hd5
`define OP_SJMP       8'h80
`define OP_LJMP       8'h02
`define OP_LCALL      8'h12
`define SFR_BASE      8'h80
`define BANK_SHIFT    3
`define EXTRA_MAX     3'h3
`endif

// ==== include/insn_timing_pkg.sv ====
// Types for the instruction length and timing decoder
// Assumes the defines header is compiled alongside
package insn_timing_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } run_state_t;
    typedef enum logic [1:0] {
        SP_DATA_RAM = 2'b00,
        SP_SFR      = 2'b01,
        SP_PROG     = 2'b10,
        SP_XDATA    = 2'b11
    } space_t;
endpackage

// ==== verilog/timing_rom.sv ====
`timescale 1ns/100ps
// Byte length and base cycle table, indexed by opcode
// Assumes the caller feeds the opcode that it registers on the same edge
module timing_rom (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] opcode,
    output logic      [1:0] len_r,
    output logic      [2:0] base_r,
    output logic      [2:0] taken_r,
    output logic            var_r
);
    `include "insn_timing_defines.svh"
    logic [1:0] len_nxt;
    logic [2:0] base_nxt;
    logic [2:0] taken_nxt;
    logic       var_nxt;

    always_comb begin
        len_nxt   = 2'h1;
        base_nxt  = 3'h1;
        taken_nxt = 3'h0;
        var_nxt   = 1'b0;
        case (opcode)
            `OP_MOVC_DP:   begin base_nxt = 3'h4; var_nxt = 1'b1; end
            `OP_MOVC_PC:   begin base_nxt = 3'h3; end
            `OP_MOVX_RD_R, 8'he3, `OP_MOVX_WR_R, 8'hf3,
            `OP_MOVX_RD_D, `OP_MOVX_WR_D: begin base_nxt = 3'h3; end
            `OP_MOV_DP:    begin len_nxt = 2'h3; base_nxt = 3'h3; end
            `OP_CLR_A, `OP_RL_A, `OP_RLC_A, `OP_RR_A, `OP_RRC_A,
            `OP_SWAP_A:    begin base_nxt = 3'h1; end
            `OP_CPL_A:     begin base_nxt = 3'h2; end
            `OP_XCHD_0, `OP_XCHD_1: begin base_nxt = 3'h2; end
            `OP_PUSH, `OP_POP: begin len_nxt = 2'h2; base_nxt = 3'h2; end
            `OP_JC, `OP_JNC, `OP_JZ, `OP_JNZ: begin
                len_nxt = 2'h2; base_nxt = 3'h2; taken_nxt = 3'h4; var_nxt = 1'b1;
            end
            `OP_JB, `OP_JNB, `OP_JBC, `OP_DJNZ_DIR: begin
                len_nxt = 2'h3; base_nxt = 3'h3; taken_nxt = 3'h5; var_nxt = 1'b1;
            end
            `OP_JMP_IND:   begin base_nxt = 3'h3; var_nxt = 1'b1; end
            `OP_CJNE_DIR:  begin
                len_nxt = 2'h3; base_nxt = 3'h4; taken_nxt = 3'h6; var_nxt = 1'b1;
            end
            8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf: begin
                len_nxt = 2'h3; base_nxt = 3'h3; taken_nxt = 3'h5; var_nxt = 1'b1;
            end
            `OP_SJMP:      begin len_nxt = 2'h2; base_nxt = 3'h4; var_nxt = 1'b1; end
            `OP_LJMP, `OP_LCALL: begin len_nxt = 2'h3; base_nxt = 3'h5; var_nxt = 1'b1; end
            `OP_UNUSED, `OP_NOP: begin len_nxt = 2'h1; base_nxt = 3'h1; end
            default: begin
                if (opcode[3:0] == 4'h1) begin
                    len_nxt  = 2'h2;
                    base_nxt = 3'h4;
                    var_nxt  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            len_r   <= 2'h1;
            base_r  <= 3'h1;
            taken_r <= 3'h0;
            var_r   <= 1'b0;
        end else begin
            len_r   <= len_nxt;
            base_r  <= base_nxt;
            taken_r <= taken_nxt;
            var_r   <= var_nxt;
        end
    end
endmodule // timing_rom

// ==== verilog/insn_timing.sv ====
// Instruction decode and cycle timing for a pipelined 8-bit core
// Assumes opcode/operands are valid with start; flash timing and alignment are inputs
// Notes on behaviour
// - Code read at A plus data pointer: one byte, four to seven cycles.
// - Code read at A plus program counter: one byte, three cycles.
// - External data moves: one byte, three cycles; 8-bit or 16-bit address.
// - Load data pointer with constant: three bytes, three cycles.
// - Accumulator clear, rotates, swap take one cycle; complement takes two.
// - Low-nibble exchange with indirect RAM: one byte, two cycles.
// - Push and pop of a direct byte: two bytes, two cycles.
// - Carry jumps: two bytes, two cycles untaken, four to six taken.
// - Direct-bit jumps: three bytes, three or five to seven; clear variant clears bit.
// - Indirect jump via A plus data pointer: one byte, three to five cycles.
// - Compare A with direct and branch: three bytes, four or six to eight.
// - Compare register with immediate and branch: three bytes, three or five to seven.
// - Decrement direct and branch nonzero: three bytes, three or five to seven.
// - Branch on A zero or nonzero: two bytes, two or four to six.
// - Variable counts grow with misalignment and the flash read timing setting.
// - Relative offset is signed 8-bit, added to the next instruction address.
// - Direct address below 0x80 hits data RAM, otherwise special registers.
// - Page target keeps upper bits of next address within a 2 kB page.
// - Long target reaches anywhere in 64 kB program space.
// - The unused opcode behaves exactly as no-operation.
// - Indirect uses register zero or one; register operands pick one of eight.
// - Bank select picks one of four groups of eight RAM bytes.
`timescale 1ns/100ps
module insn_timing #(
    parameter int EXTRA_W = 2
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  start,
    input  wire logic [7:0]            opcode,
    input  wire logic [7:0]            operand1,
    input  wire logic [7:0]            operand2,
    input  wire logic [15:0]           pc_in,
    input  wire logic [15:0]           data_pointer_word,
    input  wire logic [7:0]            acc_in,
    input  wire logic                  carry_in,
    input  wire logic                  bit_in,
    input  wire logic [7:0]            direct_in,
    input  wire logic [1:0]            bank_select_field,
    input  wire logic [EXTRA_W-1:0]    flash_read_timing_setting,
    input  wire logic                  misaligned,
    output logic                       busy_r,
    output logic                       done_r,
    output logic [1:0]                 length_r,
    output logic [3:0]                 cycles_r,
    output logic                       taken_r,
    output logic [15:0]                next_pc_r,
    output logic [7:0]                 ram_addr_r,
    output insn_timing_pkg::space_t    space_r,
    output logic                       clear_bit_r,
    output logic [15:0]                code_addr_r
);
    import insn_timing_pkg::*;
    `include "insn_timing_defines.svh"

    // ----------------------------------------------------------
    // Table lookup
    // ----------------------------------------------------------
    logic [7:0]  op_r, op_nxt;
    logic [7:0]  o1_r, o1_nxt;
    logic [7:0]  o2_r, o2_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [1:0]  t_len;
    logic [2:0]  t_base;
    logic [2:0]  t_taken;
    logic        t_var;

    timing_rom u_rom (
        .clk     (clk),
        .nrst    (nrst),
        .opcode  (op_nxt),
        .len_r   (t_len),
        .base_r  (t_base),
        .taken_r (t_taken),
        .var_r   (t_var)
    );

    function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] idx);
        bank_reg = {3'h0, bank, idx};
    endfunction

    // ----------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------
    run_state_t  st_r, st_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [3:0]  total;
    logic [2:0]  extra;
    logic        cond;
    logic [15:0] seq_pc;
    logic [15:0] rel_tgt;
    logic [15:0] dest;
    logic        is_jump;
    logic [7:0]  ra_nxt;
    space_t      sp_nxt;
    logic [15:0] ca_nxt;
    logic [15:0] npc_nxt;
    logic        clr_nxt;

    always_comb begin
        op_nxt = start && st_r != ST_RUN ? opcode : op_r;
        o1_nxt = start && st_r != ST_RUN ? operand1 : o1_r;
        o2_nxt = start && st_r != ST_RUN ? operand2 : o2_r;
        pc_nxt = start && st_r != ST_RUN ? pc_in : pc_r;
    end

    always_comb begin
        seq_pc  = pc_r + {14'h0, t_len};
        cond    = 1'b0;
        is_jump = 1'b0;
        dest    = seq_pc;
        clr_nxt = 1'b0;
        case (op_r)
            `OP_JC:       cond = carry_in;
            `OP_JNC:      cond = !carry_in;
            `OP_JB:       cond = bit_in;
            `OP_JNB:      cond = !bit_in;
            `OP_JBC: begin
                cond    = bit_in;
                clr_nxt = bit_in;
            end
            `OP_CJNE_DIR: cond = acc_in != direct_in;
            `OP_JZ:       cond = acc_in == 8'h00;
            `OP_JNZ:      cond = acc_in != 8'h00;
            `OP_DJNZ_DIR: cond = (direct_in - 8'h01) != 8'h00;
            default: begin
                if (op_r[7:3] == 5'b10111) begin
                    cond = direct_in != o1_r;
                end
            end
        endcase
        // Relative operand position depends on instruction length
        rel_tgt = seq_pc + {{8{(t_len == 2'h3 ? o2_r[7] : o1_r[7])}},
                            (t_len == 2'h3 ? o2_r : o1_r)};
        if (t_taken != 3'h0) begin
            is_jump = cond;
            if (cond) begin
                dest = rel_tgt;
            end
        end else if (op_r == `OP_SJMP) begin
            is_jump = 1'b1;
            dest    = rel_tgt;
        end else if (op_r == `OP_LJMP || op_r == `OP_LCALL) begin
            is_jump = 1'b1;
            dest    = {o1_r, o2_r};
        end else if (op_r[3:0] == 4'h1) begin
            is_jump = 1'b1;
            dest    = {seq_pc[15:11], op_r[7:5], o1_r};
        end else if (op_r == `OP_JMP_IND) begin
            is_jump = 1'b1;
            dest    = data_pointer_word + {8'h00, acc_in};
        end
    end

    always_comb begin
        // Misalignment and flash wait settings stretch variable rows
        extra = t_var ? 3'({1'b0, flash_read_timing_setting} + {2'h0, misaligned}) : 3'h0;
        if (extra > `EXTRA_MAX) begin
            extra = `EXTRA_MAX;
        end
        if (t_taken != 3'h0 && !cond) begin
            total = {1'b0, t_base};
        end else if (t_taken != 3'h0) begin
            total = {1'b0, t_taken} + {1'b0, (extra > 3'h2 ? 3'h2 : extra)};
        end else if (op_r == `OP_MOVC_DP) begin
            total = {1'b0, t_base} + {1'b0, extra};
        end else begin
            total = {1'b0, t_base} + (t_var ? {1'b0, (extra > 3'h2 ? 3'h2 : extra)} : 4'h0);
        end
    end

    always_comb begin
        ra_nxt  = o1_r;
        sp_nxt  = SP_DATA_RAM;
        ca_nxt  = 16'h0000;
        if (op_r == `OP_MOVC_DP) begin
            sp_nxt = SP_PROG;
            ca_nxt = data_pointer_word + {8'h00, acc_in};
        end else if (op_r == `OP_MOVC_PC) begin
            sp_nxt = SP_PROG;
            ca_nxt = seq_pc + {8'h00, acc_in};
        end else if (op_r == `OP_MOVX_RD_D || op_r == `OP_MOVX_WR_D) begin
            sp_nxt = SP_XDATA;
            ca_nxt = data_pointer_word;
        end else if (op_r[7:1] == 7'b1110001 || op_r[7:1] == 7'b1111001) begin
            sp_nxt = SP_XDATA;
            ra_nxt = bank_reg(bank_select_field, {2'b00, op_r[0]});
        end else if (op_r[3:1] == 3'b011) begin
            ra_nxt = bank_reg(bank_select_field, {2'b00, op_r[0]});
        end else if (op_r[3] && op_r != `OP_SJMP) begin
            ra_nxt = bank_reg(bank_select_field, op_r[2:0]);
        end else if (o1_r >= `SFR_BASE) begin
            sp_nxt = SP_SFR;
        end
        npc_nxt = is_jump ? dest : seq_pc;
    end

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_IDLE, ST_DONE: begin
                st_nxt = start ? ST_RUN : ST_IDLE;
                cnt_nxt = 4'h0;
            end
            ST_RUN: begin
                // One cycle spent loading the table row
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r != 4'h0 && cnt_r >= total) begin
                    st_nxt = ST_DONE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r        <= ST_IDLE;
            cnt_r       <= 4'h0;
            op_r        <= `OP_NOP;
            o1_r        <= 8'h00;
            o2_r        <= 8'h00;
            pc_r        <= 16'h0000;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            length_r    <= 2'h1;
            cycles_r    <= 4'h0;
            taken_r     <= 1'b0;
            next_pc_r   <= 16'h0000;
            ram_addr_r  <= 8'h00;
            space_r     <= SP_DATA_RAM;
            clear_bit_r <= 1'b0;
            code_addr_r <= 16'h0000;
        end else begin
            st_r        <= st_nxt;
            cnt_r       <= cnt_nxt;
            op_r        <= op_nxt;
            o1_r        <= o1_nxt;
            o2_r        <= o2_nxt;
            pc_r        <= pc_nxt;
            busy_r      <= st_nxt == ST_RUN;
            done_r      <= st_r == ST_RUN && st_nxt == ST_DONE;
            if (st_r == ST_RUN && st_nxt == ST_DONE) begin
                length_r    <= t_len;
                cycles_r    <= total;
                taken_r     <= is_jump;
                next_pc_r   <= npc_nxt;
                ram_addr_r  <= ra_nxt;
                space_r     <= sp_nxt;
                clear_bit_r <= clr_nxt;
                code_addr_r <= ca_nxt;
            end
        end
    end
endmodule // insn_timing

// ==== testbench/insn_timing_properties.sv ====
// Checker for the instruction timing decoder, seeing only its ports
// Assumes the package and defines header are compiled first
`timescale 1ns/100ps
`include "insn_timing_defines.svh"
module insn_timing_properties
    import insn_timing_pkg::*;
#(
    parameter int EXTRA_W = 2
) (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               start,
    input wire logic [7:0]         opcode,
    input wire logic [7:0]         operand1,
    input wire logic [7:0]         operand2,
    input wire logic [15:0]        pc_in,
    input wire logic [15:0]        data_pointer_word,
    input wire logic [7:0]         acc_in,
    input wire logic               carry_in,
    input wire logic               bit_in,
    input wire logic [7:0]         direct_in,
    input wire logic [1:0]         bank_select_field,
    input wire logic [EXTRA_W-1:0] flash_read_timing_setting,
    input wire logic               misaligned,
    input wire logic               busy_r,
    input wire logic               done_r,
    input wire logic [1:0]         length_r,
    input wire logic [3:0]         cycles_r,
    input wire logic               taken_r,
    input wire logic [15:0]        next_pc_r,
    input wire logic [7:0]         ram_addr_r,
    input wire insn_timing_pkg::space_t space_r,
    input wire logic               clear_bit_r,
    input wire logic [15:0]        code_addr_r
);
    // ------------------------------------------------------------
    // Opcode held from the taking edge
    // ------------------------------------------------------------
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    always_comb op_nxt = (start && !busy_r) ? opcode : op_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) op_r <= 8'h00;
        else op_r <= op_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_done; start && !busy_r |=> busy_r ##[1:10] done_r; endproperty
    a_done: assert property (p_done) else $error("no completion after take");
    property p_pulse; done_r |-> !busy_r ##1 !done_r; endproperty
    a_pulse: assert property (p_pulse) else $error("done not a single idle pulse");
    property p_nop;
        done_r && op_r == `OP_UNUSED |-> length_r == 2'h1 && cycles_r == 4'h1 && !taken_r;
    endproperty
    a_nop: assert property (p_nop) else $error("unused opcode not a nop");
    property p_acc;
        done_r && op_r inside {8'he4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4, 8'hf4}
            |-> length_r == 2'h1 && cycles_r == (op_r == `OP_CPL_A ? 4'h2 : 4'h1);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator op timing");
    property p_movx;
        done_r && op_r inside {8'he2, 8'he3, 8'hf2, 8'hf3, 8'he0, 8'hf0}
            |-> length_r == 2'h1 && cycles_r == 4'h3 && space_r == SP_XDATA;
    endproperty
    a_movx: assert property (p_movx) else $error("external move timing");
    property p_movc;
        done_r && op_r == `OP_MOVC_DP |-> cycles_r inside {[4'h4:4'h7]} && space_r == SP_PROG;
    endproperty
    a_movc: assert property (p_movc) else $error("code read timing");
    property p_cjump;
        done_r && op_r inside {`OP_JC, `OP_JNC} |-> length_r == 2'h2
            && (taken_r ? cycles_r inside {[4'h4:4'h6]} : cycles_r == 4'h2);
    endproperty
    a_cjump: assert property (p_cjump) else $error("carry jump timing");
    property p_jind;
        done_r && op_r == `OP_JMP_IND |-> taken_r && cycles_r inside {[4'h3:4'h5]};
    endproperty
    a_jind: assert property (p_jind) else $error("indirect jump timing");
    property p_clr; done_r && clear_bit_r |-> op_r == `OP_JBC && taken_r; endproperty
    a_clr: assert property (p_clr) else $error("bit clear outside taken test");
    property p_cjne;
        done_r && op_r == `OP_CJNE_DIR |-> length_r == 2'h3
            && (taken_r ? cycles_r inside {[4'h6:4'h8]} : cycles_r == 4'h4);
    endproperty
    a_cjne: assert property (p_cjne) else $error("compare branch timing");
    c_taken: cover property (done_r && taken_r);
    c_nop: cover property (done_r && op_r == `OP_UNUSED);
    c_refused: cover property (start && busy_r);
endmodule // insn_timing_properties

bind insn_timing insn_timing_properties #(.EXTRA_W(EXTRA_W)) u_props (.*);

// ==== testbench/tb_insn_timing.sv ====
// Self-checking bench for the instruction timing decoder
// Assumes the checker file is compiled with the design
`timescale 1ns/100ps
`include "insn_timing_defines.svh"
module tb_insn_timing;
    import insn_timing_pkg::*;
    logic        clk, nrst, start, carry_in, bit_in, misaligned;
    logic        busy_r, done_r, taken_r, clear_bit_r;
    logic [7:0]  opcode, operand1, operand2, acc_in, direct_in, ram_addr_r;
    logic [15:0] pc_in, data_pointer_word, next_pc_r, code_addr_r;
    logic [1:0]  bank_select_field, flash_read_timing_setting, length_r;
    logic [3:0]  cycles_r;
    space_t      space_r;
    int          mismatches, checked;
    insn_timing #(.EXTRA_W(2)) dut_u (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wdone();
        int n;
        n = 0;
        while (done_r !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (done_r !== 1'b1) begin
            mismatches++;
            $display("ERROR done_r expected 1 seen %b", done_r);
            test_done();
        end
    endtask
    task automatic run(input logic [7:0] op, o1, o2, input logic [15:0] pc);
        opcode = op;
        operand1 = o1;
        operand2 = o2;
        pc_in = pc;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wdone();
    endtask
    task automatic res(input logic [1:0] len, input logic [3:0] cyc, input logic tk,
                       input logic [15:0] npc);
        chk("length_r", {14'h0, len}, {14'h0, length_r});
        chk("cycles_r", {12'h0, cyc}, {12'h0, cycles_r});
        chk("taken_r", {15'h0, tk}, {15'h0, taken_r});
        chk("next_pc_r", npc, next_pc_r);
    endtask
    task automatic br(input logic [7:0] op, o1, o2, input logic tk, input logic [1:0] len,
                      input logic [3:0] lo);
        logic [7:0]  rel;
        logic [15:0] npc;
        rel = (len == 2'h2) ? o1 : o2;
        npc = 16'h07fe + {14'h0, len} + (tk ? {{8{rel[7]}}, rel} : 16'h0);
        run(op, o1, o2, 16'h07fe);
        res(len, tk ? lo + 4'h2 : lo, tk, npc);
        chk("clear_bit_r", {15'h0, tk && op == `OP_JBC}, {15'h0, clear_bit_r});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fixed();
        logic [15:0] t [19] = '{16'h8313, 16'he213, 16'hf213, 16'he013, 16'hf013, 16'h9033,
            16'he411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411, 16'hf412, 16'hd612,
            16'hd712, 16'hc022, 16'hd022, 16'ha511, 16'h0011};
        flash_read_timing_setting = 2'h3;
        misaligned = 1'b1;
        foreach (t[i]) begin
            run(t[i][15:8], 8'h30, 8'h00, 16'h0100);
            res(t[i][5:4], t[i][3:0], 1'b0, 16'h0100 + {14'h0, t[i][5:4]});
        end
        $display("test fixed done");
    endtask
    task automatic t_var();
        int e;
        acc_in = 8'h10;
        data_pointer_word = 16'h12f8;
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                flash_read_timing_setting = 2'(s);
                misaligned = 1'(m);
                e = s + m;
                run(`OP_MOVC_DP, 8'h00, 8'h00, 16'h0200);
                res(2'h1, 4'(4 + (e > 3 ? 3 : e)), 1'b0, 16'h0201);
                chk("code_addr_r", 16'h1308, code_addr_r);
                run(`OP_JMP_IND, 8'h00, 8'h00, 16'h0200);
                res(2'h1, 4'(3 + (e > 2 ? 2 : e)), 1'b1, 16'h1308);
            end
        end
        $display("test variable done");
    endtask
    task automatic t_branch();
        flash_read_timing_setting = 2'h0;
        misaligned = 1'b0;
        carry_in = 1'b1;
        bit_in = 1'b1;
        acc_in = 8'h00;
        direct_in = 8'h05;
        br(`OP_JC, 8'h80, 8'h00, 1'b1, 2'h2, 4'h2);
        br(`OP_JNC, 8'h80, 8'h00, 1'b0, 2'h2, 4'h2);
        br(`OP_JB, 8'h11, 8'h7f, 1'b1, 2'h3, 4'h3);
        br(`OP_JNB, 8'h11, 8'h7f, 1'b0, 2'h3, 4'h3);
        br(`OP_JBC, 8'h11, 8'hf0, 1'b1, 2'h3, 4'h3);
        br(`OP_JZ, 8'h02, 8'h00, 1'b1, 2'h2, 4'h2);
        br(`OP_JNZ, 8'h02, 8'h00, 1'b0, 2'h2, 4'h2);
        br(`OP_SJMP, 8'hfe, 8'h00, 1'b1, 2'h2, 4'h2);
        br(`OP_DJNZ_DIR, 8'h30, 8'h05, 1'b1, 2'h3, 4'h3);
        br(8'hb8, 8'h05, 8'h10, 1'b0, 2'h3, 4'h3);
        br(8'hbf, 8'h06, 8'h10, 1'b1, 2'h3, 4'h3);
        acc_in = 8'h05;
        br(`OP_CJNE_DIR, 8'h30, 8'h20, 1'b0, 2'h3, 4'h4);
        carry_in = 1'b0;
        bit_in = 1'b0;
        direct_in = 8'h01;
        br(`OP_JNC, 8'h7f, 8'h00, 1'b1, 2'h2, 4'h2);
        br(`OP_JBC, 8'h11, 8'h10, 1'b0, 2'h3, 4'h3);
        br(`OP_DJNZ_DIR, 8'h30, 8'h05, 1'b0, 2'h3, 4'h3);
        br(`OP_CJNE_DIR, 8'h30, 8'h20, 1'b1, 2'h3, 4'h4);
        br(`OP_JNZ, 8'h02, 8'h00, 1'b1, 2'h2, 4'h2);
        $display("test branch done");
    endtask
    task automatic t_abs();
        run(8'h41, 8'h34, 8'h00, 16'h07fe);
        res(2'h2, 4'h4, 1'b1, 16'h0a34);
        run(8'h11, 8'h34, 8'h00, 16'hfffe);
        res(2'h2, 4'h4, 1'b1, 16'h0034);
        run(`OP_LJMP, 8'hab, 8'hcd, 16'h07fe);
        res(2'h3, 4'h5, 1'b1, 16'habcd);
        run(`OP_LCALL, 8'hfe, 8'h01, 16'h0000);
        res(2'h3, 4'h5, 1'b1, 16'hfe01);
        $display("test target done");
    endtask
    task automatic t_addr();
        run(`OP_PUSH, 8'h7f, 8'h00, 16'h0300);
        chk("ram_addr_r", 16'h007f, {8'h0, ram_addr_r});
        chk("space_r", {14'h0, SP_DATA_RAM}, {14'h0, space_r});
        run(`OP_POP, 8'h80, 8'h00, 16'h0300);
        chk("ram_addr_r", 16'h0080, {8'h0, ram_addr_r});
        chk("space_r", {14'h0, SP_SFR}, {14'h0, space_r});
        for (int b = 0; b < 4; b++) begin
            bank_select_field = 2'(b);
            run(8'hb8 + 8'(7 - 2 * b), 8'h00, 8'h00, 16'h0300);
            chk("ram_addr_r", 16'(b * 8 + 7 - 2 * b), {8'h0, ram_addr_r});
        end
        run(`OP_XCHD_1, 8'h00, 8'h00, 16'h0300);
        chk("ram_addr_r", 16'h0019, {8'h0, ram_addr_r});
        run(`OP_MOVX_RD_R, 8'h00, 8'h00, 16'h0300);
        chk("ram_addr_r", 16'h0018, {8'h0, ram_addr_r});
        chk("space_r", {14'h0, SP_XDATA}, {14'h0, space_r});
        run(`OP_MOVX_WR_D, 8'h00, 8'h00, 16'h0300);
        chk("code_addr_r", 16'h12f8, code_addr_r);
        chk("space_r", {14'h0, SP_XDATA}, {14'h0, space_r});
        $display("test address done");
    endtask
    task automatic t_refuse();
        opcode = `OP_MOVC_DP;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        @(negedge clk);
        opcode = `OP_CLR_A;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk("busy_r", 16'h0001, {15'h0, busy_r});
        wdone();
        chk("cycles_r", 16'h0004, {12'h0, cycles_r});
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            chk("done_r", 16'h0000, {15'h0, done_r});
        end
        $display("test refused done");
    endtask
    initial begin
        mismatches = 0;
        checked = 0;
        nrst = 1'b0;
        start = 1'b0;
        opcode = 8'h00;
        operand1 = 8'h00;
        operand2 = 8'h00;
        pc_in = 16'h0000;
        data_pointer_word = 16'h0000;
        acc_in = 8'h00;
        carry_in = 1'b0;
        bit_in = 1'b0;
        direct_in = 8'h00;
        bank_select_field = 2'h0;
        flash_read_timing_setting = 2'h0;
        misaligned = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        t_fixed();
        t_var();
        t_branch();
        t_abs();
        t_addr();
        t_refuse();
        test_done();
    end
endmodule // tb_insn_timing
